/* File: hw/fifo_mem.sv */
`timescale 1ns/100ps
module fifo_mem
    import uart_shadow_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              wr_en,
    input  wire logic [PTR_W-1:0]  wr_addr,
    input  wire logic [BYTE_W-1:0] wr_data,
    input  wire logic [PTR_W-1:0]  rd_addr,
    output logic      [BYTE_W-1:0] rd_data
);
    logic [BYTE_W-1:0] mem [2**PTR_W];

    // Storage write, no reset needed
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read; a new head shows one cycle after the pointer moves
    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule : fifo_mem

/* File: hw/uart_shadow.sv */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
// Behaviour
// - Sixteen consecutive words alias one receive/transmit buffer for burst access.
// - Reads return the received byte in bits 7:0, serial or infrared input.
// - Without FIFOs an unread byte is overwritten and overrun is flagged.
// - With FIFOs a buffer read returns the receive FIFO head.
// - Full receive FIFO keeps entries, drops newcomer, flags overrun.
// - Written bytes go out on serial line or active-low infrared output.
// - Without FIFOs a write clears the transmit-holding-empty flag.
// - Without FIFOs further writes replace the pending transmit byte.
// - With FIFOs writes are accepted until sixteen bytes are queued.
// - Writes to a full transmit FIFO are dropped, contents unchanged.
module uart_shadow
    import uart_shadow_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [31:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        sin,
    input  wire logic        sir_in,
    output logic             sout,
    output logic             sir_out_n,
    output logic             irq
);
    typedef enum {RD_IDLE, RD_WAIT, RD_RESP} rd_state_e;
    typedef enum {TX_IDLE, TX_LOAD, TX_SEND} tx_state_e;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

    logic aw_full_q, w_full_q, wr_fire, tx_push, flush;
    logic [31:0] awaddr_q, wdata_q, araddr_q, rd_mux;
    logic [3:0] wstrb_q;
    reg_sel_e wr_sel, rd_sel;
    rd_state_e rd_state_q;
    logic rd_pop, lsr_read;
    logic fifo_en_q, ir_mode_q;
    logic [PTR_W-1:0] rx_wr_ptr_q, rx_rd_ptr_q, tx_wr_ptr_q, tx_rd_ptr_q;
    logic [CNT_W-1:0] rx_count_q, tx_count_q;
    logic [BYTE_W-1:0] rx_mem_rd, tx_mem_rd, rx_hold_q, tx_hold_q, rx_sh_q;
    logic rx_hold_full_q, tx_hold_full_q, rx_push, rx_pop, tx_push_fifo, tx_take;
    logic rx_done, rx_in, ovr_event, ovr_q, rx_valid, tx_avail, tx_holding_empty_flag, tx_holding_empty_flag_q;
    logic [IRQ_W-1:0] isr_q, imr_q, events, isr_clr;
    tx_state_e tx_state_q;
    rx_state_e rx_state_q;
    logic [BAUD_W-1:0] tx_baud_q, rx_baud_q;
    logic [3:0] tx_idx_q;
    logic [2:0] rx_idx_q;
    logic [9:0] tx_sh_q;
    logic tx_line;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side: address and data taken in either order
    assign awready = !aw_full_q && !bvalid;
    assign wready  = !w_full_q && !bvalid;
    assign wr_fire = aw_full_q && w_full_q && !bvalid;
    assign wr_sel  = decode(awaddr_q);
    assign tx_push = wr_fire && wr_sel == SEL_ALIAS && wstrb_q[0];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_full_q <= 1'b1;
                awaddr_q  <= awaddr;
            end else if (wr_fire) begin
                aw_full_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_full_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end else if (wr_fire) begin
                w_full_q <= 1'b0;
            end
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Control and mask registers; a FIFO-enable change flushes both paths
    assign flush = wr_fire && wr_sel == SEL_CTRL && wstrb_q[0]
                   && wdata_q[CTRL_FIFO_EN_BIT] != fifo_en_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fifo_en_q <= 1'b0;
            ir_mode_q <= 1'b0;
            imr_q     <= '0;
        end else if (wr_fire && wstrb_q[0]) begin
            if (wr_sel == SEL_CTRL) begin
                fifo_en_q <= wdata_q[CTRL_FIFO_EN_BIT];
                ir_mode_q <= wdata_q[CTRL_IR_BIT];
            end
            if (wr_sel == SEL_IMR) begin
                imr_q <= wdata_q[IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read side; the wait state lets the FIFO head settle
    assign arready  = rd_state_q == RD_IDLE;
    assign rvalid   = rd_state_q == RD_RESP;
    assign rd_sel   = decode(araddr_q);
    assign rd_pop   = rd_state_q == RD_WAIT && rd_sel == SEL_ALIAS;
    assign lsr_read = rd_state_q == RD_WAIT && rd_sel == SEL_LSR;

    always_comb begin
        rd_mux = '0;
        unique case (rd_sel)
            SEL_ALIAS: rd_mux[BYTE_W-1:0] = fifo_en_q ? rx_mem_rd : rx_hold_q;
            SEL_CTRL: begin
                rd_mux[CTRL_FIFO_EN_BIT] = fifo_en_q;
                rd_mux[CTRL_IR_BIT]      = ir_mode_q;
            end
            SEL_LSR: begin
                rd_mux[LSR_RXV_BIT]  = rx_valid;
                rd_mux[LSR_OVR_BIT]  = ovr_q;
                rd_mux[LSR_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag;
            end
            SEL_ISR:  rd_mux[IRQ_W-1:0] = isr_q;
            SEL_IMR:  rd_mux[IRQ_W-1:0] = imr_q;
            SEL_NONE: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_state_q <= RD_IDLE;
            araddr_q   <= '0;
            rdata      <= '0;
            rresp      <= RESP_OKAY;
        end else begin
            unique case (rd_state_q)
                RD_IDLE: if (arvalid) begin
                    araddr_q   <= araddr;
                    rd_state_q <= RD_WAIT;
                end
                RD_WAIT: begin
                    rdata      <= rd_mux;
                    rresp      <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
                    rd_state_q <= RD_RESP;
                end
                RD_RESP: if (rready) rd_state_q <= RD_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive storage: single holding byte or sixteen-entry FIFO
    assign rx_pop    = rd_pop && fifo_en_q && rx_count_q != '0;
    assign rx_push   = rx_done && fifo_en_q && (rx_count_q != FIFO_DEPTH || rx_pop);
    assign ovr_event = rx_done && (fifo_en_q ? !rx_push : rx_hold_full_q && !rd_pop);
    assign rx_valid  = fifo_en_q ? rx_count_q != '0 : rx_hold_full_q;

    always_ff @(posedge clk) begin
        if (sys_rst || flush) begin
            rx_wr_ptr_q <= '0;
            rx_rd_ptr_q <= '0;
            rx_count_q  <= '0;
        end else begin
            if (rx_push) rx_wr_ptr_q <= rx_wr_ptr_q + 1'b1;
            if (rx_pop) rx_rd_ptr_q <= rx_rd_ptr_q + 1'b1;
            if (rx_push && !rx_pop) rx_count_q <= rx_count_q + 1'b1;
            else if (rx_pop && !rx_push) rx_count_q <= rx_count_q - 1'b1;
        end
    end

    // Holding byte: a new arrival beats the read that would clear it
    always_ff @(posedge clk) begin
        if (sys_rst || flush) begin
            rx_hold_q      <= '0;
            rx_hold_full_q <= 1'b0;
        end else if (rx_done && !fifo_en_q) begin
            rx_hold_q      <= rx_sh_q;
            rx_hold_full_q <= 1'b1;
        end else if (rd_pop) begin
            rx_hold_full_q <= 1'b0;
        end
    end

    fifo_mem u_rx_mem (
        .clk     (clk),
        .wr_en   (rx_push),
        .wr_addr (rx_wr_ptr_q),
        .wr_data (rx_sh_q),
        .rd_addr (rx_rd_ptr_q),
        .rd_data (rx_mem_rd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transmit storage: holding byte or FIFO, full FIFO drops the write
    assign tx_push_fifo = tx_push && fifo_en_q && tx_count_q != FIFO_DEPTH;
    assign tx_avail     = fifo_en_q ? tx_count_q != '0 : tx_hold_full_q;
    assign tx_holding_empty_flag         = !tx_avail;
    assign tx_take      = tx_state_q == TX_LOAD && tx_avail;

    always_ff @(posedge clk) begin
        if (sys_rst || flush) begin
            tx_wr_ptr_q <= '0;
            tx_rd_ptr_q <= '0;
            tx_count_q  <= '0;
        end else begin
            if (tx_push_fifo) tx_wr_ptr_q <= tx_wr_ptr_q + 1'b1;
            if (tx_take && fifo_en_q) tx_rd_ptr_q <= tx_rd_ptr_q + 1'b1;
            if (tx_push_fifo && !(tx_take && fifo_en_q)) tx_count_q <= tx_count_q + 1'b1;
            else if (tx_take && fifo_en_q && !tx_push_fifo) tx_count_q <= tx_count_q - 1'b1;
        end
    end

    // A write in the load cycle still wins, so that byte is sent next
    always_ff @(posedge clk) begin
        if (sys_rst || flush) begin
            tx_hold_q      <= '0;
            tx_hold_full_q <= 1'b0;
        end else if (tx_push && !fifo_en_q) begin
            tx_hold_q      <= wdata_q[BYTE_W-1:0];
            tx_hold_full_q <= 1'b1;
        end else if (tx_take) begin
            tx_hold_full_q <= 1'b0;
        end
    end

    fifo_mem u_tx_mem (
        .clk     (clk),
        .wr_en   (tx_push_fifo),
        .wr_addr (tx_wr_ptr_q),
        .wr_data (wdata_q[BYTE_W-1:0]),
        .rd_addr (tx_rd_ptr_q),
        .rd_data (tx_mem_rd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter, 8N1; infrared drives a low level for each zero bit
    assign tx_line   = (tx_state_q == TX_SEND) ? tx_sh_q[0] : 1'b1;
    assign sout      = ir_mode_q ? 1'b1 : tx_line;
    assign sir_out_n = ir_mode_q ? tx_line : 1'b1;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_state_q <= TX_IDLE;
            tx_sh_q    <= '1;
            tx_baud_q  <= '0;
            tx_idx_q   <= '0;
        end else begin
            unique case (tx_state_q)
                TX_IDLE: if (tx_avail) tx_state_q <= TX_LOAD;
                TX_LOAD: begin
                    tx_sh_q    <= {1'b1, fifo_en_q ? tx_mem_rd : tx_hold_q, 1'b0};
                    tx_baud_q  <= '0;
                    tx_idx_q   <= '0;
                    tx_state_q <= tx_avail ? TX_SEND : TX_IDLE;
                end
                TX_SEND: if (tx_baud_q == BIT_LAST) begin
                    tx_baud_q <= '0;
                    tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
                    tx_idx_q  <= tx_idx_q + 1'b1;
                    if (tx_idx_q == FRAME_LAST) tx_state_q <= TX_IDLE;
                end else begin
                    tx_baud_q <= tx_baud_q + 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver, mid-bit sampling; a bad stop bit discards the byte
    assign rx_in   = ir_mode_q ? !sir_in : sin;
    assign rx_done = rx_state_q == RX_STOP && rx_baud_q == BIT_LAST && rx_in;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_state_q <= RX_IDLE;
            rx_baud_q  <= '0;
            rx_idx_q   <= '0;
            rx_sh_q    <= '0;
        end else begin
            rx_baud_q <= rx_baud_q + 1'b1;
            unique case (rx_state_q)
                RX_IDLE: begin
                    rx_baud_q <= '0;
                    if (!rx_in) rx_state_q <= RX_START;
                end
                RX_START: if (rx_baud_q == BIT_MID) begin
                    rx_baud_q  <= '0;
                    rx_idx_q   <= '0;
                    rx_state_q <= rx_in ? RX_IDLE : RX_DATA;
                end
                RX_DATA: if (rx_baud_q == BIT_LAST) begin
                    rx_baud_q <= '0;
                    rx_sh_q   <= {rx_in, rx_sh_q[BYTE_W-1:1]};
                    rx_idx_q  <= rx_idx_q + 1'b1;
                    if (rx_idx_q == DATA_LAST) rx_state_q <= RX_STOP;
                end
                RX_STOP: if (rx_baud_q == BIT_LAST) rx_state_q <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status and interrupts; a set always beats a clear in the same cycle
    assign events[IRQ_RX_BIT]  = rx_push || (rx_done && !fifo_en_q);
    assign events[IRQ_OVR_BIT] = ovr_event;
    assign events[IRQ_TXE_BIT] = tx_holding_empty_flag && !tx_holding_empty_flag_q;
    assign isr_clr = (wr_fire && wr_sel == SEL_ISR && wstrb_q[0]) ? wdata_q[IRQ_W-1:0] : '0;
    assign irq     = |(isr_q & imr_q);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            isr_q  <= '0;
            ovr_q  <= 1'b0;
            tx_holding_empty_flag_q <= 1'b1;
        end else begin
            isr_q  <= (isr_q & ~isr_clr) | events;
            ovr_q  <= ovr_event || (ovr_q && !lsr_read);
            tx_holding_empty_flag_q <= tx_holding_empty_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_ar_alias;
        arvalid && arready && decode(araddr) == SEL_ALIAS;
    endsequence
    sequence s_tx_start;
        tx_state_q == TX_LOAD && tx_avail;
    endsequence

    AST_ALIAS_OKAY: assert property (s_ar_alias |-> ##2 (rvalid && rresp == RESP_OKAY))
        else $error("alias read did not answer OKAY in two cycles");
    AST_RX_HOLD: assert property (rx_done && !fifo_en_q && !flush
                                  |=> rx_hold_full_q && rx_hold_q == $past(rx_sh_q))
        else $error("received byte not placed in holding byte");
    AST_RX_OVERRUN: assert property (rx_done && !fifo_en_q && rx_hold_full_q && !rd_pop
                                     |=> ovr_q && isr_q[IRQ_OVR_BIT])
        else $error("overwrite without overrun flag");
    AST_RX_HEAD: assert property (rx_pop |=> rvalid && rdata[BYTE_W-1:0] == $past(rx_mem_rd))
        else $error("buffer read did not return FIFO head");
    AST_RX_FULL_DROP: assert property (rx_done && fifo_en_q && rx_count_q == FIFO_DEPTH
                                       && !rx_pop && !flush
                                       |=> $stable(rx_wr_ptr_q) && rx_count_q == FIFO_DEPTH
                                       && ovr_q)
        else $error("full receive FIFO changed or overrun missed");
    AST_TX_START: assert property (s_tx_start |=> (ir_mode_q ? !sir_out_n : !sout)
                                   [*2])
        else $error("start bit missing on selected output");
    AST_TX_HOLDING_EMPTY_FLAG_CLEAR: assert property (tx_push && !fifo_en_q && tx_holding_empty_flag && !flush |=> !tx_holding_empty_flag)
        else $error("write did not clear holding-empty");
    AST_TX_REPLACE: assert property (tx_push && !fifo_en_q && !flush
                                     |=> tx_hold_q == $past(wdata_q[BYTE_W-1:0]))
        else $error("pending transmit byte not replaced");
    AST_TX_ACCEPT: assert property (tx_push && fifo_en_q && tx_count_q < FIFO_DEPTH && !flush
                                    |=> tx_wr_ptr_q == PTR_W'($past(tx_wr_ptr_q) + 1'b1))
        else $error("transmit FIFO refused a write with room");
    AST_TX_FULL_DROP: assert property (tx_push && fifo_en_q && tx_count_q == FIFO_DEPTH
                                       && !flush |=> $stable(tx_wr_ptr_q))
        else $error("write to full transmit FIFO was stored");
endmodule : uart_shadow

/* File: include/uart_shadow_pkg.sv */
package uart_shadow_pkg;
    // Register map, byte addresses
    localparam logic [31:0] ALIAS_BASE  = 32'h5000_1130;
    localparam logic [31:0] ALIAS_SPAN  = 32'h0000_0040;
    localparam logic [31:0] ALIAS3_ADDR = 32'h5000_113C;
    localparam logic [31:0] ALIAS4_ADDR = 32'h5000_1140;
    localparam logic [31:0] CTRL_ADDR   = 32'h5000_1180;
    localparam logic [31:0] LSR_ADDR    = 32'h5000_1184;
    localparam logic [31:0] ISR_ADDR    = 32'h5000_1188;
    localparam logic [31:0] IMR_ADDR    = 32'h5000_118C;

    // Field positions
    localparam int CTRL_FIFO_EN_BIT = 0;
    localparam int CTRL_IR_BIT      = 1;
    localparam int LSR_RXV_BIT      = 0;
    localparam int LSR_OVR_BIT      = 1;
    localparam int LSR_TX_HOLDING_EMPTY_FLAG_BIT     = 5;
    localparam int IRQ_RX_BIT       = 0;
    localparam int IRQ_OVR_BIT      = 1;
    localparam int IRQ_TXE_BIT      = 2;
    localparam int IRQ_W            = 3;

    // Buffer geometry
    localparam int BYTE_W = 8;
    localparam int PTR_W  = 4;
    localparam int CNT_W  = 5;
    localparam logic [CNT_W-1:0] FIFO_DEPTH = 5'h10;

    // Serial timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int BIT_TIME_NS   = 8600;
    localparam int BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int BAUD_W        = 8;
    localparam logic [BAUD_W-1:0] BIT_LAST = BAUD_W'(BIT_CYCLES - 1);
    localparam logic [BAUD_W-1:0] BIT_MID  = BAUD_W'(BIT_CYCLES / 2 - 1);
    localparam logic [3:0] FRAME_LAST = 4'h9;
    localparam logic [2:0] DATA_LAST  = 3'h7;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {SEL_NONE, SEL_ALIAS, SEL_CTRL, SEL_LSR, SEL_ISR, SEL_IMR} reg_sel_e;

    function automatic reg_sel_e decode(input logic [31:0] addr);
        if (addr >= ALIAS_BASE && addr < ALIAS_BASE + ALIAS_SPAN) return SEL_ALIAS;
        unique case (addr)
            CTRL_ADDR: return SEL_CTRL;
            LSR_ADDR:  return SEL_LSR;
            ISR_ADDR:  return SEL_ISR;
            IMR_ADDR:  return SEL_IMR;
            default:   return SEL_NONE;
        endcase
    endfunction : decode
endpackage : uart_shadow_pkg

/* File: verification/remote_uart.sv */
`timescale 1ns/100ps
module remote_uart
    import uart_shadow_pkg::*;
(
    input  wire logic       ir,
    input  wire logic       sout,
    input  wire logic       sir_out_n,
    output logic            sin = 1'b1,
    output logic            sir_in = 1'b0,
    output logic [7:0]      rx_byte = 8'h00,
    output logic            rx_tgl = 1'b0
);
    // Unused output of each mode idles high, so one line carries both
    wire line = sout & sir_out_n;

    // Frame out LSB first; second stop bit gives the receiver room
    task automatic send(input logic [7:0] b);
        logic [10:0] f;
        f = {2'b11, b, 1'b0};
        #(CLK_PERIOD_NS / 2);
        for (int i = 0; i < 11; i++) begin
            sin = ir | f[i];
            sir_in = ir & ~f[i];
            #(BIT_TIME_NS);
        end
        #(CLK_PERIOD_NS / 2); // Hand back on a rising edge, where bus calls start
    endtask : send

    ////////////////////////////////////////
    // Mid-bit sampling; a short start bit is not filtered
    always begin
        @(negedge line);
        #(BIT_TIME_NS / 2);
        for (int i = 0; i < 8; i++) begin
            #(BIT_TIME_NS);
            rx_byte[i] = line;
        end
        #(BIT_TIME_NS);
        rx_tgl = ~rx_tgl;
    end
endmodule : remote_uart

/* File: verification/test_uart_shadow_buffer_access.sv */
`timescale 1ns/100ps
module test_uart_shadow_buffer_access
    import uart_shadow_pkg::*;
;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, seed = 32'hD580;
    logic [3:0]  wstrb = 4'hF;
    logic [2:0]  awprot = '0, arprot = '0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, ir = 0;
    wire         awready, wready, bvalid, arready, rvalid, sout, sir_out_n, irq;
    wire         sin, sir_in, rx_tgl;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [7:0]   rx_byte;
    int          errors = 0, total_checks = 0;
    logic [33:0] exp_rd[$];
    logic [7:0]  exp_tx[$];
    logic [1:0]  exp_b[$];
    logic [7:0]  b[18];

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    uart_shadow dut (.clk, .sys_rst, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .sin, .sir_in, .sout, .sir_out_n, .irq);
    remote_uart peer (.ir, .sout, .sir_out_n, .sin, .sir_in, .rx_byte, .rx_tgl);

    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic [33:0] ok(input logic [31:0] d);
        return {RESP_OKAY, d};
    endfunction : ok

    task automatic tally(input logic good, input string what);
        total_checks++;
        if (good !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : tally

    // One compare per kind of result, all counted by tally
    task automatic cmp_word(input logic [33:0] got, input logic [33:0] want);
        tally(got === want, "read word");
    endtask : cmp_word

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] want);
        tally(got === want, "write response");
    endtask : cmp_resp

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] want);
        tally(got === want, "serial byte");
    endtask : cmp_byte

    task automatic cmp_irq(input logic want, input string what);
        tally(irq === want, what);
    endtask : cmp_irq

    task automatic print_verdict();
        if (exp_rd.size() + exp_tx.size() + exp_b.size() != 0) errors++;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    // Handshakes sampled at the falling edge, where the comb readies have settled
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] resp);
        logic ta, tw, tb;
        int n = 0;
        exp_b.push_back(resp);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end while (tb !== 1'b1 && n < 100);
        bready <= 1'b0;
        @(posedge clk);
        if (tb !== 1'b1) print_verdict();
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [33:0] e);
        logic ta, tr;
        int n = 0;
        exp_rd.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = arvalid & arready;
            tr = rvalid;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            n++;
        end while (tr !== 1'b1 && n < 100);
        rready <= 1'b0;
        @(posedge clk);
        if (tr !== 1'b1) print_verdict();
    endtask : rd

    // Serial frames take hundreds of cycles each, so the bound is generous
    task automatic drain(input int lim);
        int n = 0;
        while (exp_tx.size() != 0 && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (exp_tx.size() != 0) print_verdict();
    endtask : drain

    ////////////////////////////////////////
    // Results are matched against the oldest note, in issue order
    always @(negedge clk) begin
        if (rvalid && rready) cmp_word({rresp, rdata}, exp_rd.pop_front());
        if (bvalid && bready) cmp_resp(bresp, exp_b.pop_front());
    end
    always @(rx_tgl) cmp_byte(rx_byte, exp_tx.pop_front());

    initial begin
        for (int i = 0; i < 18; i++) begin
            seed = lfsr(lfsr(lfsr(seed)));
            b[i] = seed[7:0];
        end
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset values, then an unmapped place both ways
        rd(LSR_ADDR, ok(32'h20));
        rd(CTRL_ADDR, ok(32'h0));
        rd(ISR_ADDR, ok(32'h0));
        rd(IMR_ADDR, ok(32'h0));
        rd(32'h5000_1190, {RESP_SLVERR, 32'h0});
        wr(32'h5000_1190, 32'hFF, RESP_SLVERR);
        // Third write lands while the second still waits and replaces it
        exp_tx = '{b[0], b[2]};
        wr(ALIAS3_ADDR, 32'(b[0]), RESP_OKAY);
        wr(ALIAS4_ADDR, 32'(b[1]), RESP_OKAY);
        wr(ALIAS3_ADDR, 32'(b[2]), RESP_OKAY);
        rd(LSR_ADDR, ok(32'h00));
        drain(3000);
        // Unread byte overwritten; interrupt raised, masked and cleared
        wr(IMR_ADDR, 32'h1, RESP_OKAY);
        peer.send(b[3]);
        cmp_irq(1'b1, "irq raised");
        peer.send(b[4]);
        rd(LSR_ADDR, ok(32'h23));
        rd(ISR_ADDR, ok(32'h7));
        wr(IMR_ADDR, 32'h0, RESP_OKAY);
        cmp_irq(1'b0, "irq masked");
        wr(IMR_ADDR, 32'h1, RESP_OKAY);
        cmp_irq(1'b1, "irq unmasked");
        // Low strobe lane off: the write is answered but must not land
        wstrb <= 4'h0;
        wr(IMR_ADDR, 32'h0, RESP_OKAY);
        wstrb <= 4'hF;
        cmp_irq(1'b1, "irq kept on lane-less write");
        rd(ALIAS4_ADDR, ok(32'(b[4])));
        wr(ISR_ADDR, 32'h7, RESP_OKAY);
        cmp_irq(1'b0, "irq cleared");
        // Infrared with FIFOs: seventeen bytes arrive for sixteen places
        wr(CTRL_ADDR, 32'h3, RESP_OKAY);
        rd(CTRL_ADDR, ok(32'h3));
        ir <= 1'b1;
        for (int i = 0; i < 17; i++) peer.send(b[i]);
        rd(LSR_ADDR, ok(32'h23));
        for (int i = 0; i < 16; i++) rd(ALIAS_BASE + 32'(4 * i), ok(32'(b[i])));
        rd(LSR_ADDR, ok(32'h20));
        // Shifter takes one, FIFO sixteen, the last is lost
        for (int i = 0; i < 18; i++) begin
            if (i < 17) exp_tx.push_back(b[i]);
            wr(ALIAS_BASE + 32'(4 * (i % 16)), 32'(b[i]), RESP_OKAY);
        end
        drain(20000);
        print_verdict();
    end
endmodule : test_uart_shadow_buffer_access
